// [common/umx_params.svh]
`ifndef UMX_PARAMS_SVH
`define UMX_PARAMS_SVH

// System clocks per oversampling tick (16 ticks make one bit)
`define UMX_OVS_DIV 4
// Last oversampling tick of a bit period
`define UMX_OVS_LAST 4'hf
// Oversampling ticks at which the three majority samples are taken
`define UMX_SMP_A 4'h7
`define UMX_SMP_B 4'h8
`define UMX_SMP_C 4'h9
// Payload bits (data plus parity) for each word length selection
`define UMX_PAY_SHORT 4'h8
`define UMX_PAY_LONG 4'h9
// Reset values
`define UMX_TX_EMPTY_RST 1'b1
`define UMX_SHIFT_RST 11'h7ff

`endif

// [common/umx_pkg.sv]
package umx_pkg;

  // Static configuration and enable bits driven by software
  typedef struct packed {
    logic rx_enable;
    logic tx_enable;
    logic word_length_sel;
    logic parity_enable;
    logic parity_odd;
    logic parity_error_irq_en;
    logic rx_ready_irq_en;
    logic idle_irq_en;
    logic error_irq_enable;
    logic tx_dma_enable;
    logic rx_dma_enable;
    logic wake_method;
    logic half_duplex_enable;
    logic lin_mode_enable;
    logic infrared_mode_enable;
    logic [3:0] node_addr;
  } umx_cfg_t;

  // One-cycle clear pulses for the sticky flags
  typedef struct packed {
    logic parity_error;
    logic framing_error;
    logic noise_error;
    logic overrun_error;
    logic idle_line;
    logic tx_complete;
  } umx_clr_t;

  // Status seen by software
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_ready_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic noise_error_flag;
    logic overrun_error_flag;
    logic idle_line_flag;
    logic mute_control;
  } umx_status_t;

  typedef enum logic {UMX_TX_IDLE, UMX_TX_SEND} umx_tx_state_t;
  typedef enum logic {UMX_RX_IDLE, UMX_RX_BITS} umx_rx_state_t;

endpackage

// [hw/umx_parity.sv]
// Parity over the low nbits_i bits; odd_i turns even parity into odd
module umx_parity (
  // Word and format
  input wire logic [8:0] data_i,
  input wire logic [3:0] nbits_i,
  input wire logic odd_i,
  // Parity bit that completes the word
  output logic parity_o
);

  logic [8:0] mask_w;

  // Bits above the data width never count
  assign mask_w = ~(9'h1ff << nbits_i);
  assign parity_o = (^(data_i & mask_w)) ^ odd_i;

endmodule

// [hw/umx_core.sv]
`include "umx_params.svh"
module umx_core import umx_pkg::*; #(
  parameter int OVS_DIV = `UMX_OVS_DIV
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Configuration and flag clears
  input wire umx_cfg_t cfg_i,
  input wire umx_clr_t clr_i,
  // Data register access (software or DMA)
  input wire logic data_wr_i,
  input wire logic [8:0] data_wdata_i,
  input wire logic data_rd_i,
  output logic [8:0] data_rdata_o,
  // Mute control write
  input wire logic mute_wr_i,
  input wire logic mute_wdata_i,
  // Status, DMA requests and interrupt
  output umx_status_t status_o,
  output logic dma_tx_req_o,
  output logic dma_rx_req_o,
  output logic irq_o,
  // Serial pins; TX is open-drain style in half-duplex
  input wire logic rx_i,
  input wire logic tx_pin_i,
  output logic tx_o,
  output logic tx_oe_o
);

  // Oversampling tick divider
  logic [15:0] os_cnt_q;
  logic os_tick;

  assign os_tick = (os_cnt_q == 16'(OVS_DIV - 1));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || os_tick) begin
      os_cnt_q <= 16'h0000;
    end else begin
      os_cnt_q <= os_cnt_q + 16'h0001;
    end
  end

  // Frame geometry: payload width and data width
  logic [3:0] nb;
  logic [3:0] nd;
  logic [8:0] mask_nb;
  logic [8:0] mask_nd;

  assign nb = cfg_i.word_length_sel ? `UMX_PAY_LONG : `UMX_PAY_SHORT;
  assign nd = nb - {3'h0, cfg_i.parity_enable};
  assign mask_nb = ~(9'h1ff << nb);
  assign mask_nd = ~(9'h1ff << nd);

  // Transmit holding register and shifter
  umx_tx_state_t tx_state_q;
  logic [8:0] tx_hold_q;
  logic tx_empty_q;
  logic tx_done_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_os_q;
  logic [3:0] tx_bit_q;
  logic tx_par;
  logic [8:0] tx_payload;
  logic [10:0] tx_frame;
  logic tx_load;
  logic tx_bit_end;
  logic tx_last;

  umx_parity u_tx_parity (
    .data_i(tx_hold_q),
    .nbits_i(nd),
    .odd_i(cfg_i.parity_odd),
    .parity_o(tx_par)
  );

  // Parity replaces the bit just above the data
  assign tx_payload = cfg_i.parity_enable ?
    ((tx_hold_q & mask_nd) | (tx_par ? (9'h001 << nd) : 9'h000)) :
    (tx_hold_q & mask_nb);
  assign tx_frame = {1'b1, tx_payload, 1'b0} | (11'h001 << (nb + 4'h1));
  assign tx_load = (tx_state_q == UMX_TX_IDLE) && !tx_empty_q && cfg_i.tx_enable;
  assign tx_bit_end = (tx_state_q == UMX_TX_SEND) && os_tick && (tx_os_q == `UMX_OVS_LAST);
  assign tx_last = tx_bit_end && (tx_bit_q == nb + 4'h1);

  // Transmit sequencing; shifter refills with ones so the line idles high
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_state_q <= UMX_TX_IDLE;
      tx_sh_q <= `UMX_SHIFT_RST;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end else begin
      case (tx_state_q)
        UMX_TX_IDLE: begin
          if (tx_load) begin
            tx_state_q <= UMX_TX_SEND;
            tx_sh_q <= tx_frame;
            tx_os_q <= 4'h0;
            tx_bit_q <= 4'h0;
          end
        end
        UMX_TX_SEND: begin
          if (os_tick) begin
            tx_os_q <= tx_os_q + 4'h1;
          end
          if (tx_bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
          end
          if (tx_last) begin
            tx_state_q <= UMX_TX_IDLE;
          end
        end
        default: begin
          tx_state_q <= UMX_TX_IDLE;
        end
      endcase
    end
  end

  // Holding register; a write in the load cycle keeps the new word pending
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_hold_q <= 9'h000;
      tx_empty_q <= `UMX_TX_EMPTY_RST;
      tx_done_q <= 1'b0;
    end else begin
      if (data_wr_i) begin
        tx_hold_q <= data_wdata_i;
      end
      tx_empty_q <= data_wr_i ? 1'b0 : (tx_load ? 1'b1 : tx_empty_q);
      tx_done_q <= (tx_last && tx_empty_q) || (tx_done_q && !clr_i.tx_complete);
    end
  end

  // Line drive: released in half-duplex unless a frame is in flight
  assign tx_o = tx_sh_q[0];
  assign tx_oe_o = !cfg_i.half_duplex_enable || (tx_state_q == UMX_TX_SEND);

  // Receive line source; half-duplex listens on the TX wire
  logic rx_line;

  assign rx_line = cfg_i.half_duplex_enable ? tx_pin_i : rx_i;

  // Receive sampler
  umx_rx_state_t rx_state_q;
  logic [3:0] rx_os_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [2:0] rx_smp_q;
  logic rx_nz_q;
  logic rx_maj;
  logic rx_dis;
  logic rx_bit_end;
  logic rx_end;

  assign rx_maj = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2]) |
    (rx_smp_q[1] & rx_smp_q[2]);
  assign rx_dis = !((&rx_smp_q) || !(|rx_smp_q));
  assign rx_bit_end = (rx_state_q == UMX_RX_BITS) && os_tick && (rx_os_q == `UMX_OVS_LAST);
  assign rx_end = rx_bit_end && (rx_bit_q == nb + 4'h1);

  // Three-sample majority per bit; disagreement marks noise for the frame
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_state_q <= UMX_RX_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_smp_q <= 3'h0;
      rx_nz_q <= 1'b0;
    end else begin
      case (rx_state_q)
        UMX_RX_IDLE: begin
          if (os_tick && !rx_line && cfg_i.rx_enable) begin
            rx_state_q <= UMX_RX_BITS;
            rx_os_q <= 4'h1;
            rx_bit_q <= 4'h0;
            rx_nz_q <= 1'b0;
          end
        end
        UMX_RX_BITS: begin
          if (os_tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `UMX_SMP_A || rx_os_q == `UMX_SMP_B || rx_os_q == `UMX_SMP_C) begin
              rx_smp_q <= {rx_smp_q[1:0], rx_line};
            end
          end
          if (rx_bit_end) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            rx_nz_q <= rx_nz_q | rx_dis;
            if (rx_bit_q != 4'h0 && rx_bit_q <= nb) begin
              rx_sh_q <= {rx_maj, rx_sh_q[8:1]};
            end
            // A start bit that reads high was a glitch
            if ((rx_bit_q == 4'h0 && rx_maj) || rx_end) begin
              rx_state_q <= UMX_RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_q <= UMX_RX_IDLE;
        end
      endcase
    end
  end

  // Received word decode
  logic [8:0] rx_pay;
  logic [9:0] rx_pay_ext;
  logic [8:0] rx_data;
  logic rx_calc_par;
  logic rx_par_bad;
  logic rx_is_addr;
  logic rx_match;

  assign rx_pay = cfg_i.word_length_sel ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  assign rx_pay_ext = {1'b0, rx_pay};
  assign rx_data = rx_pay & mask_nd;
  assign rx_is_addr = rx_data[nd - 4'h1];
  assign rx_match = (rx_data[3:0] == cfg_i.node_addr);

  umx_parity u_rx_parity (
    .data_i(rx_data),
    .nbits_i(nd),
    .odd_i(cfg_i.parity_odd),
    .parity_o(rx_calc_par)
  );

  assign rx_par_bad = cfg_i.parity_enable && (rx_calc_par != rx_pay_ext[nd]);

  // Idle-line detector: a full frame time of high line after activity
  logic [7:0] idle_cnt_q;
  logic idle_arm_q;
  logic [7:0] idle_len;
  logic [3:0] nb_p2;
  logic idle_evt;

  assign nb_p2 = nb + 4'h2;
  assign idle_len = {nb_p2, 4'h0} - 8'h01;
  assign idle_evt = idle_arm_q && os_tick && (idle_cnt_q == idle_len) &&
    (rx_state_q == UMX_RX_IDLE) && rx_line;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || rx_state_q != UMX_RX_IDLE || !rx_line) begin
      idle_cnt_q <= 8'h00;
    end else if (os_tick && idle_cnt_q != idle_len) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end

  // Receive outcome: mute handling decides whether the word is delivered
  logic mute_q;
  logic addr_evt;
  logic wake_addr;
  logic drop_addr;
  logic wake_idle;
  logic deliver;
  logic mute_d;

  assign addr_evt = rx_end && cfg_i.wake_method && rx_is_addr;
  assign wake_addr = addr_evt && rx_match;
  assign drop_addr = addr_evt && !rx_match;
  assign wake_idle = idle_evt && mute_q && !cfg_i.wake_method;
  assign deliver = rx_end && ((!mute_q && !drop_addr) || wake_addr);

  // Hardware wake and mute win over a software write in the same cycle
  assign mute_d = wake_addr ? 1'b0 :
    drop_addr ? 1'b1 :
    wake_idle ? 1'b0 :
    (mute_wr_i && !status_o.rx_ready_flag) ? mute_wdata_i : mute_q;

  // Receive buffer and sticky flags; every set beats its clear
  logic [8:0] rx_buf_q;
  logic rx_ready_q;
  logic pe_q;
  logic fe_q;
  logic ne_q;
  logic ore_q;
  logic idle_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mute_q <= 1'b0;
      idle_arm_q <= 1'b0;
      rx_buf_q <= 9'h000;
      rx_ready_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      ne_q <= 1'b0;
      ore_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      mute_q <= mute_d;
      idle_arm_q <= rx_end || (mute_d && !mute_q) || (idle_arm_q && !idle_evt);
      if (deliver && (!rx_ready_q || data_rd_i)) begin
        rx_buf_q <= rx_data;
      end
      rx_ready_q <= deliver || (rx_ready_q && !data_rd_i);
      pe_q <= (deliver && rx_par_bad) || (pe_q && !clr_i.parity_error);
      fe_q <= (deliver && !rx_maj) || (fe_q && !clr_i.framing_error);
      ne_q <= (deliver && (rx_nz_q || rx_dis)) || (ne_q && !clr_i.noise_error);
      ore_q <= (deliver && rx_ready_q && !data_rd_i) ||
        (ore_q && !clr_i.overrun_error);
      idle_q <= (idle_evt && !mute_q) || (idle_q && !clr_i.idle_line);
    end
  end

  // Outputs
  logic err_any;

  assign data_rdata_o = rx_buf_q;
  assign status_o = '{tx_empty_flag: tx_empty_q, tx_complete_flag: tx_done_q,
    rx_ready_flag: rx_ready_q, parity_error_flag: pe_q, framing_error_flag: fe_q,
    noise_error_flag: ne_q, overrun_error_flag: ore_q, idle_line_flag: idle_q,
    mute_control: mute_q};
  assign dma_tx_req_o = cfg_i.tx_dma_enable && tx_empty_q;
  assign dma_rx_req_o = cfg_i.rx_dma_enable && rx_ready_q;
  assign err_any = fe_q || ne_q || ore_q;
  // Receive sources are masked while muted
  assign irq_o = !mute_q && ((cfg_i.parity_error_irq_en && pe_q) ||
    (cfg_i.rx_ready_irq_en && rx_ready_q) || (cfg_i.idle_irq_en && idle_q) ||
    (cfg_i.error_irq_enable && cfg_i.rx_dma_enable && err_any));

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_addr_word;
    rx_end && cfg_i.wake_method && rx_is_addr;
  endsequence

  property p_even_parity;
    tx_load && cfg_i.parity_enable && !cfg_i.parity_odd |-> !(^(tx_payload & mask_nb));
  endproperty
  a_even_parity: assert property (p_even_parity) else $error("even parity wrong");

  property p_odd_parity;
    tx_load && cfg_i.parity_enable && cfg_i.parity_odd |-> (^(tx_payload & mask_nb));
  endproperty
  a_odd_parity: assert property (p_odd_parity) else $error("odd parity wrong");

  property p_parity_flag;
    deliver && rx_par_bad |=> status_o.parity_error_flag;
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity flag missed");

  property p_tx_dma;
    cfg_i.tx_dma_enable && data_wr_i |=> !dma_tx_req_o;
  endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("tx dma request stuck");

  property p_rx_read;
    data_rd_i && !deliver |=> !status_o.rx_ready_flag;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("ready not cleared");

  property p_mute_quiet;
    mute_q && rx_end && !wake_addr |=> !$rose(rx_ready_q) && !irq_o;
  endproperty
  a_mute_quiet: assert property (p_mute_quiet) else $error("muted word flagged");

  property p_idle_wake;
    wake_idle |=> !mute_q && !idle_q ##1 !$rose(idle_q);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

  property p_addr_miss;
    s_addr_word ##0 !rx_match |=> mute_q && !$rose(rx_ready_q);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("mismatch not muted");

  property p_addr_hit;
    s_addr_word ##0 rx_match |=> !mute_q && rx_ready_q;
  endproperty
  a_addr_hit: assert property (p_addr_hit) else $error("match did not wake");

  property p_mute_ignore;
    mute_wr_i && rx_ready_q && !rx_end && !idle_evt |=> $stable(mute_q);
  endproperty
  a_mute_ignore: assert property (p_mute_ignore) else $error("mute write not ignored");

  property p_hd_release;
    cfg_i.half_duplex_enable && tx_state_q == UMX_TX_IDLE |-> !tx_oe_o && tx_o;
  endproperty
  a_hd_release: assert property (p_hd_release) else $error("tx line held");

  property p_err_irq;
    !mute_q && cfg_i.error_irq_enable && cfg_i.rx_dma_enable && fe_q |-> irq_o;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq missing");

endmodule

// [verification/umx_node.sv]
// Far-side serial node: sends and receives frames at 16 clocks per bit
module umx_node (
  // Bench clock
  input wire logic clk_i,
  // Line level seen and level driven
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BitLen = 16;

  // Released line idles high, as a pulled-up wire does
  initial line_o = 1'b1;

  // Start, payload LSB first, then the stop level asked for
  task automatic send(input logic [8:0] pay, input int nb, input logic stop);
    @(negedge clk_i);
    line_o = 1'b0;
    repeat (BitLen) @(negedge clk_i);
    for (int i = 0; i < nb; i++) begin
      line_o = pay[i];
      repeat (BitLen) @(negedge clk_i);
    end
    line_o = stop;
    repeat (BitLen) @(negedge clk_i);
    line_o = 1'b1;
  endtask

  // Eight data bits with a one-clock flip in the middle of the first one
  task automatic send_noisy(input logic [8:0] pay);
    @(negedge clk_i);
    line_o = 1'b0;
    repeat (BitLen) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o = pay[i];
      repeat (BitLen / 2) @(negedge clk_i);
      line_o = (i == 0) ? ~pay[0] : pay[i];
      @(negedge clk_i);
      line_o = pay[i];
      repeat (BitLen / 2 - 1) @(negedge clk_i);
    end
    line_o = 1'b1;
    repeat (BitLen) @(negedge clk_i);
  endtask

  // Hunt the start under a bound, then sample each bit near its middle
  task automatic get(input int nb, output logic [8:0] pay, output logic stop, output bit ok);
    int n;
    n = 0;
    pay = '0;
    while (line_i !== 1'b0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    ok = (n < 400);
    repeat (BitLen / 2) @(negedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (BitLen) @(negedge clk_i);
      pay[i] = line_i;
    end
    repeat (BitLen) @(negedge clk_i);
    stop = line_i;
  endtask
endmodule

// [verification/tb.sv]
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end

module tb import umx_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, reset_i, data_wr, data_rd, mute_wr, mute_wdata;
  logic dma_tx, dma_rx, irq, tx, tx_oe, node_drv, wire_lvl, rx_pin, stp;
  logic [8:0] wdata, rdata, pay;
  umx_cfg_t cfg;
  umx_clr_t clr;
  umx_status_t st;
  int num_errors, samples_checked;
  bit ok;
  localparam logic [2:0] Fmts [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};

  // Shared wire: a released driver leaves the pull-up in charge
  assign wire_lvl = (tx_oe ? tx : 1'b1) & node_drv;
  // RX pin held low in half-duplex so that any use of it shows
  assign rx_pin = cfg.half_duplex_enable ? 1'b0 : node_drv;

  umx_core #(.OVS_DIV(1)) i_umx_core (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_i(cfg), .clr_i(clr),
    .data_wr_i(data_wr), .data_wdata_i(wdata), .data_rd_i(data_rd), .data_rdata_o(rdata),
    .mute_wr_i(mute_wr), .mute_wdata_i(mute_wdata), .status_o(st), .dma_tx_req_o(dma_tx),
    .dma_rx_req_o(dma_rx), .irq_o(irq), .rx_i(rx_pin), .tx_pin_i(wire_lvl), .tx_o(tx),
    .tx_oe_o(tx_oe));

  umx_node i_umx_node (.clk_i(ref_clk_i), .line_i(wire_lvl), .line_o(node_drv));

  // 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [8:0] dmask(logic [8:0] d, logic wl, logic pe);
    return d & (wl ? (pe ? 9'h0ff : 9'h1ff) : (pe ? 9'h07f : 9'h0ff));
  endfunction

  // Payload as it must travel: data bits then the parity bit on top
  function automatic logic [8:0] mkpay(logic [8:0] d, logic wl, logic pe, logic odd);
    logic [8:0] m;
    m = dmask(d, wl, pe);
    if (pe) m[wl ? 8 : 7] = (^m) ^ odd;
    return m;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // One-cycle strobes, raised and dropped at falling edges
  task automatic wr(input logic [8:0] d);
    tick(1);
    data_wr = 1'b1;
    wdata = d;
    tick(1);
    data_wr = 1'b0;
  endtask

  task automatic rd;
    tick(1);
    data_rd = 1'b1;
    tick(1);
    data_rd = 1'b0;
  endtask

  task automatic mw(input logic v);
    tick(1);
    mute_wr = 1'b1;
    mute_wdata = v;
    tick(1);
    mute_wr = 1'b0;
  endtask

  task automatic clr_all;
    tick(1);
    clr = '1;
    tick(1);
    clr = '0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (st.rx_ready_flag !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      $display("unexpected rx_ready_flag: expected 1, seen %b", st.rx_ready_flag);
      give_verdict();
    end
  endtask

  task automatic rx_word(input logic [8:0] p, input logic [8:0] exp);
    i_umx_node.send(p, cfg.word_length_sel ? 9 : 8, 1'b1);
    wait_ready();
    `CHK("rx data", exp, rdata)
  endtask

  // Frames that must raise neither the ready flag nor the interrupt
  task automatic rx_none(input logic [8:0] p);
    i_umx_node.send(p, 8, 1'b1);
    tick(20);
    `CHK("rx_ready_flag", 1'b0, st.rx_ready_flag)
    `CHK("irq", 1'b0, irq)
  endtask

  // Main sequence; LIN and infrared stay off throughout
  initial begin
    int n;
    cfg = '0;
    clr = '0;
    {data_wr, data_rd, mute_wr, mute_wdata} = 4'h0;
    wdata = '0;
    num_errors = 0;
    samples_checked = 0;
    cfg.rx_enable = 1'b1;
    cfg.tx_enable = 1'b1;
    reset_i = 1'b1;
    tick(8);
    reset_i = 1'b0;
    `CHK("status", 9'h100, st)
    `CHK("tx idle", 1'b1, tx)
    `CHK("rx data", 9'h000, rdata)
    cfg.tx_dma_enable = 1'b1;
    cfg.rx_dma_enable = 1'b1;
    // Every frame format except long words with even parity, both directions, with DMA requests
    for (int f = 0; f < 5; f++) begin
      {cfg.word_length_sel, cfg.parity_enable, cfg.parity_odd} = Fmts[f];
      tick(2);
      `CHK("tx dma req", 1'b1, dma_tx)
      wr(9'h1c5);
      `CHK("tx dma req", 1'b0, dma_tx)
      i_umx_node.get(cfg.word_length_sel ? 9 : 8, pay, stp, ok);
      `CHK("tx start", 1'b1, ok)
      `CHK("tx payload", mkpay(9'h1c5, Fmts[f][2], Fmts[f][1], Fmts[f][0]), pay)
      `CHK("tx stop", 1'b1, stp)
      rx_word(mkpay(9'h1b3, Fmts[f][2], Fmts[f][1], Fmts[f][0]),
              dmask(9'h1b3, Fmts[f][2], Fmts[f][1]));
      `CHK("parity err", 1'b0, st.parity_error_flag)
      `CHK("rx dma req", 1'b1, dma_rx)
      rd();
      `CHK("rx_ready_flag", 1'b0, st.rx_ready_flag)
      `CHK("rx dma req", 1'b0, dma_rx)
    end
    // Corrupted parity bit
    {cfg.word_length_sel, cfg.parity_enable, cfg.parity_odd} = 3'h2;
    cfg.parity_error_irq_en = 1'b1;
    rx_word(mkpay(9'h055, 1'b0, 1'b1, 1'b0) ^ 9'h080, 9'h055);
    `CHK("parity err", 1'b1, st.parity_error_flag)
    `CHK("irq", 1'b1, irq)
    rd();
    clr_all();
    `CHK("irq", 1'b0, irq)
    // Framing then overrun in multi-buffer mode
    cfg.parity_enable = 1'b0;
    cfg.error_irq_enable = 1'b1;
    i_umx_node.send(9'h0a5, 8, 1'b0);
    wait_ready();
    `CHK("framing err", 1'b1, st.framing_error_flag)
    `CHK("irq", 1'b1, irq)
    i_umx_node.send(9'h05a, 8, 1'b1);
    tick(20);
    `CHK("overrun err", 1'b1, st.overrun_error_flag)
    `CHK("rx data", 9'h0a5, rdata)
    rd();
    clr_all();
    `CHK("irq", 1'b0, irq)
    // One disagreeing sample: data still good, noise flagged
    i_umx_node.send_noisy(9'h0a5);
    wait_ready();
    `CHK("noise err", 1'b1, st.noise_error_flag)
    `CHK("rx data", 9'h0a5, rdata)
    `CHK("irq", 1'b1, irq)
    rd();
    clr_all();
    `CHK("irq", 1'b0, irq)
    cfg.rx_dma_enable = 1'b0;
    i_umx_node.send(9'h0a5, 8, 1'b0);
    wait_ready();
    `CHK("framing err", 1'b1, st.framing_error_flag)
    `CHK("irq", 1'b0, irq)
    rd();
    clr_all();
    // Address-mark wake-up
    cfg.wake_method = 1'b1;
    cfg.node_addr = 4'h5;
    cfg.rx_ready_irq_en = 1'b1;
    rx_word(9'h042, 9'h042);
    mw(1'b1);
    `CHK("mute", 1'b0, st.mute_control)
    rd();
    mw(1'b1);
    `CHK("mute", 1'b1, st.mute_control)
    rx_none(9'h015);
    rx_none(9'h083);
    `CHK("mute", 1'b1, st.mute_control)
    rx_word(9'h095, 9'h095);
    `CHK("mute", 1'b0, st.mute_control)
    rd();
    rx_none(9'h086);
    `CHK("mute", 1'b1, st.mute_control)
    // Idle-line wake-up after a suppressed frame
    cfg.wake_method = 1'b0;
    rx_none(9'h033);
    `CHK("mute", 1'b1, st.mute_control)
    n = 0;
    while (st.mute_control !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    `CHK("idle wake span", 1'b1, (n > 100 && n < 200))
    `CHK("idle flag", 1'b0, st.idle_line_flag)
    // Half-duplex; the bench only talks while the device is silent
    cfg.rx_ready_irq_en = 1'b0;
    cfg.half_duplex_enable = 1'b1;
    tick(200);
    `CHK("tx oe", 1'b0, tx_oe)
    `CHK("rx_ready_flag", 1'b0, st.rx_ready_flag)
    rx_word(9'h03c, 9'h03c);
    rd();
    wr(9'h0c3);
    i_umx_node.get(8, pay, stp, ok);
    `CHK("tx start", 1'b1, ok)
    `CHK("tx oe", 1'b1, tx_oe)
    `CHK("tx payload", 9'h0c3, pay)
    wait_ready();
    `CHK("rx data", 9'h0c3, rdata)
    tick(20);
    `CHK("tx oe", 1'b0, tx_oe)
    `CHK("tx complete", 1'b1, st.tx_complete_flag)
    rd();
    // Awake receiver: a quiet line now raises the idle flag and its interrupt
    cfg.idle_irq_en = 1'b1;
    tick(160);
    `CHK("idle flag", 1'b1, st.idle_line_flag)
    `CHK("irq", 1'b1, irq)
    give_verdict();
  end
endmodule
